// ### inc/nca_pkg.sv
// Package of constants and carrier types for the nibble ALU core
package nca_pkg;

  // Bus geometry
  localparam int          AXI_AW    = 8;       // Byte address width
  localparam int          MEM_DEPTH = 256;     // Nibbles of data memory

  // Register byte offsets
  localparam logic [7:0]  OFF_CMD    = 8'h00;  // Instruction bytes, go
  localparam logic [7:0]  OFF_STATUS = 8'h04;  // Busy and illegal flags
  localparam logic [7:0]  OFF_PTR    = 8'h08;  // Primary and secondary
  localparam logic [7:0]  OFF_MADDR  = 8'h0C;  // Memory window address
  localparam logic [7:0]  OFF_MDATA  = 8'h10;  // Memory window nibble
  localparam logic [7:0]  OFF_REGS   = 8'h14;  // Work, extension, flags

  // Response codes
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [1:0]  RESP_DECERR = 2'h3;

  // Opcode constants used by the decoder
  localparam logic [7:0]  OP_ADI   = 8'hC2;    // Add immediate prefix
  localparam logic [7:0]  OP_DMDR  = 8'hC3;    // Decrement direct
  localparam logic [7:0]  OP_IMDR  = 8'hC7;    // Increment direct
  localparam logic [7:0]  OP_ADDR  = 8'hC9;    // Add direct
  localparam logic [7:0]  OP_CI    = 8'hCA;    // Immediate compare
  localparam logic [7:0]  OP_CLI   = 8'hCB;    // Pointer low match
  localparam logic [7:0]  OP_CMB   = 8'hCD;    // Bitwise match test
  localparam logic [3:0]  SEC_HI   = 4'hF;     // Second byte upper half
  localparam logic [3:0]  LAI_HI   = 4'h8;     // Load immediate group

  // Execution sequencer, Gray coded
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CYC1 = 2'b01,
    ST_CYC2 = 2'b11
  } nca_state_e;

  // Master to slave signals
  typedef struct packed {
    logic              awvalid;
    logic [AXI_AW-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [AXI_AW-1:0] araddr;
    logic              rready;
  } nca_axi_req_s;

  // Slave to master signals
  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } nca_axi_rsp_s;

  // Whole state of the core
  typedef struct packed {
    logic [MEM_DEPTH-1:0][3:0] mem;
    nca_state_e        st;
    logic [7:0]        op1;
    logic [7:0]        op2;
    logic [3:0]        work;
    logic [3:0]        ext;
    logic              carry;
    logic              zero;
    logic [7:0]        hl;
    logic [7:0]        xy;
    logic [7:0]        maddr;
    logic              illegal;
    logic              aw_got;
    logic [AXI_AW-1:0] awaddr;
    logic              w_got;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    nca_axi_rsp_s      rsp;
  } nca_state_s;

endpackage : nca_pkg

// ### logic/nca_core.sv
// Nibble ALU, memory and load/store executor behind an AXI4-Lite slave
//
// What this block does
// - add six to work, zero flag only
// - add ten to work, zero flag only
// - invert work, zero flag, carry kept
// - rotate right through carry, carry only
// - rotate left through carry, both flags
// - work/extension copies and swap, flag effects
// - memory increment/decrement, pointer or direct
// - memory bit set/clear, clear updates zero
// - add memory nibble, zero and carry
// - add memory plus carry, both flags
// - add immediate, zero only, carry kept
// - memory minus work minus carry
// - AND/OR/XOR into work, zero only
// - AND/OR into memory, zero updated
// - compare memory with work, set flags
// - compare immediate with work, set flags
// - pointer low nibble equals immediate test
// - compare one bit work versus memory
// - pair load/store work then extension
// - load immediate into work, zero flag
// - indirect load via pointer select bit
// - store work to memory, no flags
`timescale 1ns/1ps

module nca_core (
  input  wire logic                  clk_sys,
  input  wire logic                  sys_rst,
  input  wire nca_pkg::nca_axi_req_s axi_req,
  output      nca_pkg::nca_axi_rsp_s axi_rsp
);
  import nca_pkg::*;

  nca_state_s s;       // Registered state
  nca_state_s next_s;  // Next state

  // Zero test of a 4-bit result
  function automatic logic is_zero(input logic [3:0] v);
    is_zero = (v == 4'h0);
  endfunction : is_zero

  // Instructions that carry a second byte and take two cycles
  function automatic logic two_byte(input logic [7:0] op);
    two_byte = (op == OP_ADI) || (op == OP_DMDR) || (op == OP_IMDR) ||
               (op == OP_ADDR) || (op == OP_CI) || (op == OP_CLI) ||
               (op == OP_CMB);
  endfunction : two_byte

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  wstrb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (wstrb[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    merge = r;
  endfunction : merge

  // Aligned register decode of a byte address
  function automatic logic [7:0] align(input logic [AXI_AW-1:0] a);
    align = {a[7:2], 2'b00};
  endfunction : align

  // Register image at an aligned address; unmapped places read zero
  function automatic logic [31:0] image(input nca_state_s v,
                                        input logic [7:0] a);
    case (a)
      OFF_CMD:    image = {16'h0000, v.op1, v.op2};
      OFF_STATUS: image = {30'h0, v.illegal, v.st != ST_IDLE};
      OFF_PTR:    image = {16'h0000, v.xy, v.hl};
      OFF_MADDR:  image = {24'h000000, v.maddr};
      OFF_MDATA:  image = {28'h0000000, v.mem[v.maddr]};
      OFF_REGS:   image = {22'h0, v.zero, v.carry, v.ext, v.work};
      default:    image = 32'h0000_0000;
    endcase
  endfunction : image

  assign axi_rsp = s.rsp;

  // Next-state logic: bus slave, then instruction execution
  always_comb begin
    logic [3:0]  m;     // Nibble at primary pointer
    logic [3:0]  md;    // Nibble at direct address
    logic [3:0]  imm;   // Immediate of second byte
    logic [4:0]  sum;   // Sum or difference with carry out
    logic [31:0] old;   // Register image before a write
    logic [31:0] wv;    // Merged write image
    logic [7:0]  wa;    // Aligned write address
    logic [1:0]  b;     // Bit selector
    logic        last;  // Final cycle of the instruction
    logic        sec_ok; // Second byte has the mandatory upper half
    m      = s.mem[s.hl];
    md     = s.mem[s.op2];
    imm    = s.op2[3:0];
    sum    = 5'h00;
    old    = 32'h0000_0000;
    wv     = 32'h0000_0000;
    wa     = align(s.awaddr);
    b      = 2'h0;
    last   = 1'b0;
    sec_ok = (s.op2[7:4] == SEC_HI);
    next_s = s;

    // Address and data channels are taken independently
    if (axi_req.awvalid && s.rsp.awready) begin
      next_s.aw_got      = 1'b1;
      next_s.awaddr      = axi_req.awaddr;
      next_s.rsp.awready = 1'b0;
    end
    if (axi_req.wvalid && s.rsp.wready) begin
      next_s.w_got      = 1'b1;
      next_s.wdata      = axi_req.wdata;
      next_s.wstrb      = axi_req.wstrb;
      next_s.rsp.wready = 1'b0;
    end
    if (!s.aw_got && !s.w_got && !s.rsp.bvalid) begin
      next_s.rsp.awready = !(axi_req.awvalid && s.rsp.awready);
      next_s.rsp.wready  = !(axi_req.wvalid && s.rsp.wready);
    end

    // Write commit once both halves are held
    if (s.aw_got && s.w_got && !s.rsp.bvalid) begin
      next_s.aw_got     = 1'b0;
      next_s.w_got      = 1'b0;
      next_s.rsp.bvalid = 1'b1;
      next_s.rsp.bresp  = RESP_OKAY;
      case (wa)
        OFF_CMD, OFF_PTR, OFF_MADDR, OFF_MDATA, OFF_REGS: begin
          // Everything but reads is refused while an instruction runs
          if (s.st != ST_IDLE) begin
            next_s.rsp.bresp = RESP_SLVERR;
          end else begin
            // Unwritten byte lanes keep the register's present image
            old = image(s, wa);
            wv  = merge(old, s.wdata, s.wstrb);
            case (wa)
              OFF_CMD: begin
                // Writing the instruction bytes starts execution
                {next_s.op1, next_s.op2} = wv[15:0];
                next_s.illegal           = 1'b0;
                next_s.st                = ST_CYC1;
              end
              OFF_PTR:   {next_s.xy, next_s.hl} = wv[15:0];
              OFF_MADDR: next_s.maddr = wv[7:0];
              OFF_MDATA: next_s.mem[s.maddr] = wv[3:0];
              // Work, extension, carry and zero in one word
              default:   {next_s.zero, next_s.carry, next_s.ext,
                          next_s.work} = wv[9:0];
            endcase
          end
        end
        OFF_STATUS: begin
          // Read-only register
          next_s.rsp.bresp = RESP_SLVERR;
        end
        default: begin
          next_s.rsp.bresp = RESP_DECERR;
        end
      endcase
    end

    // Write response held until taken, then channels reopen
    if (s.rsp.bvalid && axi_req.bready) begin
      next_s.rsp.bvalid  = 1'b0;
      next_s.rsp.awready = 1'b1;
      next_s.rsp.wready  = 1'b1;
    end

    // Read channel, one read at a time
    if (axi_req.arvalid && s.rsp.arready) begin
      next_s.rsp.arready = 1'b0;
      next_s.rsp.rvalid  = 1'b1;
      next_s.rsp.rresp   = RESP_OKAY;
      next_s.rsp.rdata   = image(s, align(axi_req.araddr));
      // Places beyond the last register answer with a decode error
      if (align(axi_req.araddr) > OFF_REGS) begin
        next_s.rsp.rresp = RESP_DECERR;
      end
    end
    if (s.rsp.rvalid && axi_req.rready) begin
      next_s.rsp.rvalid  = 1'b0;
      next_s.rsp.arready = 1'b1;
    end

    // Sequencer: one cycle per instruction byte
    case (s.st)
      ST_IDLE: last = 1'b0;
      ST_CYC1: begin
        last = !two_byte(s.op1);
        if (!last) begin
          next_s.st = ST_CYC2;
        end
      end
      ST_CYC2: last = 1'b1;
      default: next_s.st = ST_IDLE;
    endcase

    // Instruction effect lands on the last cycle
    if (last) begin
      next_s.st = ST_IDLE;
      b = s.op1[1:0];
      if (s.op1[7:4] == LAI_HI) begin
        next_s.work = s.op1[3:0];
        next_s.zero = is_zero(s.op1[3:0]);
      end else begin
        case (s.op1)
          OP_ADI: begin
            sum         = {1'b0, s.work} + {1'b0, imm};
            next_s.work = sum[3:0];
            next_s.zero = is_zero(sum[3:0]);
          end
          8'h18: {next_s.zero, next_s.work} = {is_zero(~s.work), ~s.work};
          // Carry clear and set
          8'h1E: next_s.carry = 1'b0;
          8'h1F: next_s.carry = 1'b1;
          8'h14, 8'h24: begin
            // Work increment or decrement
            sum = (s.op1 == 8'h14) ? {1'b0, s.work} + 5'h01
                                   : {1'b0, s.work} - 5'h01;
            next_s.work  = sum[3:0];
            next_s.carry = (s.op1 == 8'h14) ? sum[4] : !sum[4];
            next_s.zero  = is_zero(sum[3:0]);
          end
          8'h10: {next_s.work, next_s.carry} = {s.carry, s.work};
          8'h01: begin
            {next_s.carry, next_s.work} = {s.work, s.carry};
            next_s.zero = is_zero({s.work[2:0], s.carry});
          end
          8'h45: next_s.ext = s.work;
          8'h46: {next_s.zero, next_s.work} = {is_zero(s.ext), s.ext};
          8'h44: {next_s.work, next_s.ext} = {s.ext, s.work};
          8'h12, 8'h22, OP_IMDR, OP_DMDR: begin
            sum = {1'b0, (s.op1 == OP_IMDR || s.op1 == OP_DMDR) ? md : m};
            if (s.op1 == 8'h12 || s.op1 == OP_IMDR) begin
              sum          = sum + 5'h01;
              next_s.carry = sum[4];
            end else begin
              sum          = sum - 5'h01;
              next_s.carry = !sum[4];
            end
            if (s.op1 == 8'h12 || s.op1 == 8'h22) begin
              next_s.mem[s.hl] = sum[3:0];
            end else begin
              next_s.mem[s.op2] = sum[3:0];
            end
            next_s.zero = is_zero(sum[3:0]);
          end
          8'h0C, 8'h0D, 8'h0E, 8'h0F: next_s.mem[s.hl][b] = 1'b1;
          8'h2C, 8'h2D, 8'h2E, 8'h2F: begin
            next_s.mem[s.hl][b] = 1'b0;
            next_s.zero = is_zero(m & ~(4'h1 << b));
          end
          8'h06, OP_ADDR, 8'h02: begin
            sum = {1'b0, s.work} +
                  {1'b0, (s.op1 == OP_ADDR) ? md : m} +
                  {4'h0, (s.op1 == 8'h02) & s.carry};
            next_s.work  = sum[3:0];
            next_s.carry = sum[4];
            next_s.zero  = is_zero(sum[3:0]);
          end
          8'h17: begin
            sum = {1'b0, m} - {1'b0, s.work} - {4'h0, s.carry};
            next_s.work  = sum[3:0];
            next_s.carry = !sum[4];
            next_s.zero  = is_zero(sum[3:0]);
          end
          8'h07: {next_s.zero, next_s.work} = {is_zero(s.work & m),
                                               s.work & m};
          8'h05: {next_s.zero, next_s.work} = {is_zero(s.work | m),
                                               s.work | m};
          8'h15: {next_s.zero, next_s.work} = {is_zero(s.work ^ m),
                                               s.work ^ m};
          8'h03: begin
            next_s.mem[s.hl] = s.work & m;
            next_s.zero      = is_zero(s.work & m);
          end
          8'h04: begin
            next_s.mem[s.hl] = s.work | m;
            next_s.zero      = is_zero(s.work | m);
          end
          8'h16: {next_s.carry, next_s.zero} = {m <= s.work, m == s.work};
          OP_CI: begin
            if (sec_ok) begin
              next_s.carry = (imm <= s.work);
              next_s.zero  = (imm == s.work);
            end else begin
              next_s.illegal = 1'b1;
            end
          end
          OP_CLI: begin
            if (sec_ok) begin
              next_s.zero = (s.hl[3:0] == imm);
            end else begin
              next_s.illegal = 1'b1;
            end
          end
          OP_CMB: begin
            if (sec_ok && s.op2[3:2] == 2'h0) begin
              next_s.zero = (s.work[s.op2[1:0]] == m[s.op2[1:0]]);
            end else begin
              next_s.illegal = 1'b1;
            end
          end
          8'h5C: {next_s.ext, next_s.work} = {s.mem[8'(s.hl + 8'h01)], m};
          8'h5E: begin
            next_s.mem[s.hl]               = s.work;
            next_s.mem[8'(s.hl + 8'h01)] = s.ext;
          end
          8'h48, 8'h4A: begin
            next_s.work = s.op1[1] ? s.mem[s.xy] : m;
            next_s.zero = is_zero(s.op1[1] ? s.mem[s.xy] : m);
          end
          8'h47: next_s.mem[s.hl] = s.work;
          default: begin
            // Unknown opcode has no effect but is reported
            next_s.illegal = 1'b1;
          end
        endcase
      end
    end
  end

  // State register with synchronous reset
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s             <= '0;
      s.rsp.awready <= 1'b1;
      s.rsp.wready  <= 1'b1;
      s.rsp.arready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

endmodule : nca_core

// ### test/nca_core_assertions.sv
// Bus-contract checker bound to the nibble ALU core
`timescale 1ns/1ps

module nca_core_assertions (
  input wire logic                  clk_sys,
  input wire logic                  sys_rst,
  input wire nca_pkg::nca_axi_req_s axi_req,
  input wire nca_pkg::nca_axi_rsp_s axi_rsp
);
  import nca_pkg::*;

  // One clock domain, reset disables every check
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // Write address and data taken together on one edge
  wire both_taken = axi_req.awvalid && axi_rsp.awready
                    && axi_req.wvalid && axi_rsp.wready;

  AST_B_TIMING: assert property (both_taken |=>
    !axi_rsp.bvalid ##1 axi_rsp.bvalid)
    else $error("write answer not two edges after take");
  AST_B_HOLD: assert property (axi_rsp.bvalid && !axi_req.bready |=>
    axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write answer dropped or changed early");
  AST_B_BLOCK: assert property (axi_rsp.bvalid |->
    !axi_rsp.awready && !axi_rsp.wready)
    else $error("write channels open while answer pending");
  AST_B_DROP: assert property (axi_rsp.bvalid && axi_req.bready |=>
    !axi_rsp.bvalid && axi_rsp.awready && axi_rsp.wready)
    else $error("write answer not retired cleanly");
  AST_R_TIMING: assert property (axi_req.arvalid && axi_rsp.arready |=>
    axi_rsp.rvalid)
    else $error("read answer late");
  AST_R_HOLD: assert property (axi_rsp.rvalid && !axi_req.rready |=>
    axi_rsp.rvalid && $stable(axi_rsp.rdata) && $stable(axi_rsp.rresp))
    else $error("read answer dropped or changed early");
  AST_R_BLOCK: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("read address open while answer pending");
  AST_R_DROP: assert property (axi_rsp.rvalid && axi_req.rready |=>
    !axi_rsp.rvalid && axi_rsp.arready)
    else $error("read answer not retired cleanly");
  AST_DEC_ZERO: assert property (axi_rsp.rvalid &&
    axi_rsp.rresp == RESP_DECERR |-> axi_rsp.rdata == 32'h0)
    else $error("unmapped read returned data");

  // Main traffic kinds
  COV_WRITE: cover property (both_taken ##2 axi_rsp.bvalid);
  COV_READ: cover property (axi_rsp.rvalid && axi_req.rready);
  COV_SLVERR: cover property (axi_rsp.bvalid
    && axi_rsp.bresp == RESP_SLVERR);
  COV_DECERR: cover property (axi_rsp.rvalid
    && axi_rsp.rresp == RESP_DECERR);
endmodule : nca_core_assertions

bind nca_core nca_core_assertions nca_core_assertions_i (
  .clk_sys (clk_sys),
  .sys_rst (sys_rst),
  .axi_req (axi_req),
  .axi_rsp (axi_rsp)
);

// ### test/test_nca_core.sv
// Self-checking bench for the nibble ALU core over its register bus
`timescale 1ns/1ps

module test_nca_core;
  import nca_pkg::*;

  logic         clk_sys  = 1'b0;  // 200 MHz clock
  logic         sys_rst  = 1'b1;  // Synchronous reset
  nca_axi_req_s req      = '0;    // Master side of the bus
  nca_axi_rsp_s rsp;              // Slave answers
  int           n_errors = 0;     // Mismatches
  int           n_checks = 0;     // Comparisons
  logic [31:0]  d;                // Read-back scratch

  // Half period of 2.5 ns
  always #2.5 clk_sys = ~clk_sys;

  nca_core nca_core_i (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .axi_req (req),
    .axi_rsp (rsp)
  );

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask : chk

  // One write; each channel released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] dv,
                    input logic [1:0] er);
    logic       aw, w, b;
    logic [1:0] r;
    int         n;
    b = 1'b0;
    n = 0;
    @(posedge clk_sys);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= dv;
    req.wstrb   <= 4'hF;
    req.bready  <= 1'b1;
    while (!b && n < 50) begin
      // Flops change only at rising edges, so mid-cycle is what is sampled
      @(negedge clk_sys);
      aw = req.awvalid & rsp.awready;
      w  = req.wvalid & rsp.wready;
      b  = rsp.bvalid;
      r  = rsp.bresp;
      @(posedge clk_sys);
      if (aw) req.awvalid <= 1'b0;
      if (w) req.wvalid <= 1'b0;
      if (b) req.bready <= 1'b0;
      n++;
    end
    chk({b, 29'h0, r}, {1'b1, 29'h0, er});
  endtask : wr

  // One read; data and code taken mid-cycle, before the handshake edge
  task automatic rd(input logic [7:0] a, output logic [31:0] q,
                    input logic [1:0] er);
    logic       ar, v;
    logic [1:0] r;
    int         n;
    v = 1'b0;
    n = 0;
    @(posedge clk_sys);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    while (!v && n < 50) begin
      @(negedge clk_sys);
      ar = req.arvalid & rsp.arready;
      v  = rsp.rvalid;
      q  = rsp.rdata;
      r  = rsp.rresp;
      @(posedge clk_sys);
      if (ar) req.arvalid <= 1'b0;
      if (v) req.rready <= 1'b0;
      n++;
    end
    chk({v, 29'h0, r}, {1'b1, 29'h0, er});
  endtask : rd

  // Launch one instruction and poll until it is no longer busy
  task automatic exec(input logic [7:0] o1, input logic [7:0] o2);
    int n;
    n = 0;
    wr(OFF_CMD, {16'h0, o1, o2}, RESP_OKAY);
    d = 32'h1;
    while (d[0] !== 1'b0 && n < 20) begin
      rd(OFF_STATUS, d, RESP_OKAY);
      n++;
    end
    // A poll that runs out while still busy is a mismatch
    chk({31'h0, d[0]}, 32'h0);
  endtask : exec

  // Preload {zero,carry,ext,work} and mem[0x35], run, check both
  task automatic run(input logic [7:0] o1, input logic [7:0] o2,
                     input logic [9:0] pre, input logic [3:0] m,
                     input logic [9:0] ex, input logic [3:0] em);
    wr(OFF_PTR, 32'h5A35, RESP_OKAY);
    wr(OFF_MADDR, 32'h35, RESP_OKAY);
    wr(OFF_MDATA, {28'h0, m}, RESP_OKAY);
    wr(OFF_REGS, {22'h0, pre}, RESP_OKAY);
    exec(o1, o2);
    rd(OFF_REGS, d, RESP_OKAY);
    chk(d, {22'h0, ex});
    rd(OFF_MDATA, d, RESP_OKAY);
    chk(d, {28'h0, em});
  endtask : run

  // Reset state, refused writes, unmapped place, bad second byte
  task automatic t_bus;
    rd(OFF_REGS, d, RESP_OKAY);
    chk(d, 32'h0);
    rd(OFF_PTR, d, RESP_OKAY);
    chk(d, 32'h0);
    wr(OFF_STATUS, 32'h3, RESP_SLVERR);
    wr(8'h3C, 32'h1, RESP_DECERR);
    rd(8'h3C, d, RESP_DECERR);
    chk(d, 32'h0);
    run(OP_CI, 8'h05, 10'h003, 4'h3, 10'h003, 4'h3);
    rd(OFF_STATUS, d, RESP_OKAY);
    chk(d, 32'h2);
    run(OP_CI, 8'hF3, 10'h003, 4'h3, 10'h303, 4'h3);
    rd(OFF_STATUS, d, RESP_OKAY);
    chk(d, 32'h0);
    // Unknown opcode and bad bit field: no effect, reported
    run(8'hFF, 8'h00, 10'h3A5, 4'h6, 10'h3A5, 4'h6);
    rd(OFF_STATUS, d, RESP_OKAY);
    chk(d, 32'h2);
    run(OP_CMB, 8'hF4, 10'h105, 4'h6, 10'h105, 4'h6);
    rd(OFF_STATUS, d, RESP_OKAY);
    chk(d, 32'h2);
  endtask : t_bus

  // Work register operations and transfers
  task automatic t_acc;
    run(OP_ADI, 8'h06, 10'h105, 4'h0, 10'h10B, 4'h0);
    run(OP_ADI, 8'h06, 10'h00A, 4'h0, 10'h200, 4'h0);
    run(OP_ADI, 8'h0A, 10'h006, 4'h0, 10'h200, 4'h0);
    run(OP_ADI, 8'h0A, 10'h303, 4'h0, 10'h10D, 4'h0);
    run(8'h18, 8'h00, 10'h10F, 4'h0, 10'h300, 4'h0);
    run(8'h18, 8'h00, 10'h205, 4'h0, 10'h00A, 4'h0);
    run(8'h10, 8'h00, 10'h101, 4'h0, 10'h108, 4'h0);
    run(8'h10, 8'h00, 10'h302, 4'h0, 10'h209, 4'h0);
    run(8'h01, 8'h00, 10'h008, 4'h0, 10'h300, 4'h0);
    run(8'h01, 8'h00, 10'h304, 4'h0, 10'h009, 4'h0);
    run(8'h45, 8'h00, 10'h237, 4'h0, 10'h277, 4'h0);
    run(8'h46, 8'h00, 10'h2A7, 4'h0, 10'h0AA, 4'h0);
    run(8'h46, 8'h00, 10'h003, 4'h0, 10'h200, 4'h0);
    run(8'h44, 8'h00, 10'h1A0, 4'h0, 10'h10A, 4'h0);
    // Work increment and decrement, carry set and clear
    run(8'h14, 8'h00, 10'h00F, 4'h0, 10'h300, 4'h0);
    run(8'h24, 8'h00, 10'h300, 4'h0, 10'h00F, 4'h0);
    run(8'h1F, 8'h00, 10'h005, 4'h0, 10'h105, 4'h0);
    run(8'h1E, 8'h00, 10'h305, 4'h0, 10'h205, 4'h0);
  endtask : t_acc

  // Memory increment, decrement and bit set or clear
  task automatic t_mem;
    run(8'h12, 8'h00, 10'h000, 4'hF, 10'h300, 4'h0);
    run(8'h22, 8'h00, 10'h300, 4'h0, 10'h000, 4'hF);
    run(OP_IMDR, 8'h35, 10'h200, 4'h7, 10'h000, 4'h8);
    run(OP_DMDR, 8'h35, 10'h000, 4'h1, 10'h300, 4'h0);
    for (int i = 0; i < 4; i++) begin
      run({6'h03, i[1:0]}, 8'h00, 10'h305, 4'h0, 10'h305,
          4'h1 << i);
      run({6'h0B, i[1:0]}, 8'h00, 10'h205, 4'hF, 10'h005,
          ~(4'h1 << i));
    end
    run(8'h2E, 8'h00, 10'h105, 4'h4, 10'h305, 4'h0);
  endtask : t_mem

  // Additions, subtraction and logic
  task automatic t_arith;
    run(8'h06, 8'h00, 10'h009, 4'h8, 10'h101, 4'h8);
    run(OP_ADDR, 8'h35, 10'h008, 4'h8, 10'h300, 4'h8);
    run(8'h02, 8'h00, 10'h107, 4'h8, 10'h300, 4'h8);
    run(8'h02, 8'h00, 10'h103, 4'h4, 10'h008, 4'h4);
    run(OP_ADI, 8'h03, 10'h00E, 4'h0, 10'h001, 4'h0);
    run(OP_ADI, 8'h03, 10'h10D, 4'h0, 10'h300, 4'h0);
    run(8'h17, 8'h00, 10'h103, 4'h2, 10'h00E, 4'h2);
    run(8'h17, 8'h00, 10'h102, 4'h3, 10'h300, 4'h3);
    run(8'h17, 8'h00, 10'h202, 4'h5, 10'h103, 4'h5);
    run(8'h07, 8'h00, 10'h10C, 4'hA, 10'h108, 4'hA);
    run(8'h05, 8'h00, 10'h100, 4'h0, 10'h300, 4'h0);
    run(8'h15, 8'h00, 10'h00A, 4'hA, 10'h200, 4'hA);
    run(8'h15, 8'h00, 10'h205, 4'hA, 10'h00F, 4'hA);
    run(8'h03, 8'h00, 10'h10C, 4'h3, 10'h30C, 4'h0);
    run(8'h04, 8'h00, 10'h201, 4'h2, 10'h001, 4'h3);
  endtask : t_arith

  // Compares against memory, immediate, pointer and single bits
  task automatic t_cmp;
    logic z;
    run(8'h16, 8'h00, 10'h303, 4'h5, 10'h003, 4'h5);
    run(8'h16, 8'h00, 10'h003, 4'h3, 10'h303, 4'h3);
    run(8'h16, 8'h00, 10'h203, 4'h2, 10'h103, 4'h2);
    run(OP_CI, 8'hF5, 10'h303, 4'h0, 10'h003, 4'h0);
    run(OP_CI, 8'hF2, 10'h203, 4'h0, 10'h103, 4'h0);
    run(OP_CLI, 8'hF5, 10'h103, 4'h0, 10'h303, 4'h0);
    run(OP_CLI, 8'hF6, 10'h203, 4'h0, 10'h003, 4'h0);
    for (int i = 0; i < 4; i++) begin
      // Work 0101 against memory 0110: upper two bits match
      z = (i > 1);
      run(OP_CMB, {6'h3C, i[1:0]}, {!z, 9'h105}, 4'h6,
          {z, 9'h105}, 4'h6);
    end
  endtask : t_cmp

  // Loads and stores
  task automatic t_ldst;
    wr(OFF_MADDR, 32'h36, RESP_OKAY);
    wr(OFF_MDATA, 32'h9, RESP_OKAY);
    run(8'h5C, 8'h00, 10'h300, 4'h4, 10'h394, 4'h4);
    run(8'h5E, 8'h00, 10'h0B7, 4'h0, 10'h0B7, 4'h7);
    wr(OFF_MADDR, 32'h36, RESP_OKAY);
    rd(OFF_MDATA, d, RESP_OKAY);
    chk(d, 32'hB);
    run(8'h80, 8'h00, 10'h0AB, 4'h0, 10'h2A0, 4'h0);
    run(8'h89, 8'h00, 10'h2A0, 4'h0, 10'h0A9, 4'h0);
    run(8'h48, 8'h00, 10'h007, 4'h0, 10'h200, 4'h0);
    wr(OFF_MADDR, 32'h5A, RESP_OKAY);
    wr(OFF_MDATA, 32'h6, RESP_OKAY);
    run(8'h4A, 8'h00, 10'h200, 4'h3, 10'h006, 4'h3);
    run(8'h47, 8'h00, 10'h309, 4'h0, 10'h309, 4'h9);
  endtask : t_ldst

  // Counts, verdict, end of run
  task automatic test_done;
    $display("Checks %0d, errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  // Main sequence
  initial begin
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_bus;
    t_acc;
    t_mem;
    t_arith;
    t_cmp;
    t_ldst;
    test_done;
  end

  // Hang guard, well beyond the few thousand cycles needed
  initial begin
    repeat (40000) @(posedge clk_sys);
    n_errors++;
    test_done;
  end
endmodule : test_nca_core
